// ### rdc_regs.sv
// Reference pre-divider and pin configuration register bank with effects.
`default_nettype none
// Overview of operation
// - Priority bit picks first or second level.
// - Equal priority: lowest numbered input wins.
// - Set control low holds divider in set.
// - Enable control low runs the divider.
// - Bypass feeds undivided reference onward.
// - Ratio in bits 19:0, minimum two.
// - Pull-down bit enables OE pin pull-down.
// - Pull-up bit enables OE pin pull-up.
// - Polarity bit sets OE active level.
// - Effect selector clear lets OE gate drivers.
// - Startup gating waits for chosen lock.
// - Push-pull strength drives three pads.
// - Open-drain strength drives two pads.
// - Serial data pin pull-up control.
// - Serial clock pin pull-up control.
module rdc_regs (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_en_i,
  input wire logic [1:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  input wire logic ref_clk_i,
  input wire logic [3:0] ref_valid_i,
  input wire logic [3:1] peer_priority_i,
  output logic [1:0] sel_ref_o,
  output logic sel_valid_o,
  output logic div_clk_o,
  input wire logic oe_pin_i,
  input wire logic apll_lock_i,
  input wire logic dpll_lock_i,
  output logic out_enable_o,
  output logic oe_pin_pulldown_o,
  output logic oe_pin_pullup_o,
  output logic [1:0] push_pull_strength_o,
  output logic [1:0] open_drain_strength_o,
  output logic serial_data_pullup_o,
  output logic serial_clock_pullup_o,
  output logic ratio_err_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] prediv_ff;
  logic [7:0] oe_ff;
  logic [7:0] io_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic wr_prediv;
  logic wr_oe;
  logic wr_io;
  assign wr_prediv = wr_en_i && (addr_i == rdc_pkg::REG_PREDIV);
  assign wr_oe = wr_en_i && (addr_i == rdc_pkg::REG_OE);
  assign wr_io = wr_en_i && (addr_i == rdc_pkg::REG_IO);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      prediv_ff <= rdc_pkg::PREDIV_RST;
    else if (wr_prediv)
      prediv_ff <= wdata_i & rdc_pkg::PREDIV_MASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      oe_ff <= rdc_pkg::OE_RST;
    else if (wr_oe)
      oe_ff <= wdata_i[7:0] & rdc_pkg::OE_MASK;
  end

  // Every bit of this register is writable, so no mask is applied.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      io_ff <= rdc_pkg::IO_RST;
    else if (wr_io)
      io_ff <= wdata_i[7:0];
  end

  // Reads return the register one cycle after the address is presented.
  always_comb
  begin
    case (addr_i)
      rdc_pkg::REG_PREDIV: nxt_rdata = prediv_ff;
      rdc_pkg::REG_OE: nxt_rdata = {24'h00_0000, oe_ff};
      rdc_pkg::REG_IO: nxt_rdata = {24'h00_0000, io_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rdata_ff <= 32'h0000_0000;
    else
      rdata_ff <= nxt_rdata;
  end
  assign rdata_o = rdata_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Reference selection among inputs sharing this bank's priority scheme.
  logic own_pri;
  logic [3:0] pri;
  logic [1:0] nxt_sel;
  logic nxt_sel_valid;
  logic [1:0] sel_ff;
  logic sel_valid_ff;
  assign own_pri = prediv_ff[rdc_pkg::PRI_BIT];
  assign pri = {peer_priority_i, own_pri};
  logic [3:0] lvl0_hit;
  logic [3:0] lvl1_hit;
  assign lvl0_hit = ref_valid_i & ~pri;
  assign lvl1_hit = ref_valid_i & pri;

  always_comb
  begin
    nxt_sel = 2'h0;
    nxt_sel_valid = 1'b0;
    // Scan downward so the lowest numbered valid input of a level wins.
    for (int i = 3; i >= 0; i--)
    begin
      if (lvl0_hit[i])
      begin
        nxt_sel = 2'(i);
        nxt_sel_valid = 1'b1;
      end
    end
    if (!nxt_sel_valid)
    begin
      for (int i = 3; i >= 0; i--)
      begin
        if (lvl1_hit[i])
        begin
          nxt_sel = 2'(i);
          nxt_sel_valid = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sel_ff <= 2'h0;
      sel_valid_ff <= 1'b0;
    end
    else
    begin
      sel_ff <= nxt_sel;
      sel_valid_ff <= nxt_sel_valid;
    end
  end
  assign sel_ref_o = sel_ff;
  assign sel_valid_o = sel_valid_ff;
  ////////////////////////////////////////////////////////////////////////////
  // The reference is sampled as a level, so it must be well below clk_i.
  logic ref_s;
  logic ref_d_ff;
  logic ref_rise;
  logic [rdc_pkg::RATIO_W-1:0] ratio;
  logic [rdc_pkg::RATIO_W-1:0] cnt_ff;
  logic [rdc_pkg::RATIO_W-1:0] nxt_cnt;
  logic div_ff;
  logic nxt_div;
  logic out_ff;
  logic div_hold;
  logic div_run;
  logic bypass;
  rdc_sync2 u_ref_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i(ref_clk_i),
    .q_o(ref_s)
  );
  assign ratio = prediv_ff[rdc_pkg::RATIO_MSB:0];
  assign div_hold = !prediv_ff[rdc_pkg::SETB_BIT];
  assign div_run = !prediv_ff[rdc_pkg::ENB_BIT];
  assign bypass = prediv_ff[rdc_pkg::BYP_BIT];
  assign ref_rise = ref_s && !ref_d_ff;

  logic ratio_ok;
  logic cnt_wrap;
  logic cnt_half;
  logic div_step;
  // A ratio below two would underflow the compare terms, so it never counts.
  assign ratio_ok = (ratio >= rdc_pkg::RATIO_MIN);
  assign cnt_wrap = (cnt_ff >= (ratio - rdc_pkg::RATIO_ONE));
  assign cnt_half = (cnt_ff == ((ratio >> 1) - rdc_pkg::RATIO_ONE));
  assign div_step = div_run && ref_rise && ratio_ok;

  // Counter counts reference edges; output toggles near half the ratio.
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_div = div_ff;
    if (div_hold)
    begin
      nxt_cnt = '0;
      nxt_div = 1'b1;
    end
    else if (div_step)
    begin
      if (cnt_wrap)
      begin
        nxt_cnt = '0;
        nxt_div = 1'b1;
      end
      else
      begin
        nxt_cnt = cnt_ff + rdc_pkg::RATIO_ONE;
        if (cnt_half)
          nxt_div = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ref_d_ff <= 1'b0;
    else
      ref_d_ff <= ref_s;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      div_ff <= 1'b1;
    else
      div_ff <= nxt_div;
  end

  // Bypass skips the divider stage, so it leads the divided path by a cycle.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      out_ff <= 1'b0;
    else
      out_ff <= bypass ? ref_s : div_ff;
  end

  assign div_clk_o = out_ff;

  // A ratio below the minimum is flagged unless bypass is set; division by one needs bypass.
  logic ratio_err_ff;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ratio_err_ff <= 1'b0;
    else
      ratio_err_ff <= !bypass && (ratio < rdc_pkg::RATIO_MIN);
  end
  assign ratio_err_o = ratio_err_ff;
  ////////////////////////////////////////////////////////////////////////////
  logic oe_s;
  logic apll_s;
  logic dpll_s;
  rdc_sync2 u_oe_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i(oe_pin_i),
    .q_o(oe_s)
  );
  rdc_sync2 u_apll_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i(apll_lock_i),
    .q_o(apll_s)
  );
  rdc_sync2 u_dpll_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i(dpll_lock_i),
    .q_o(dpll_s)
  );
  // Startup gate: once the chosen lock is seen, it stays open until reset.
  rdc_pkg::rdc_gate_e gate_ff;
  rdc_pkg::rdc_gate_e nxt_gate;
  logic [1:0] stup;
  logic lock_seen;
  assign stup = io_ff[rdc_pkg::STUP_MSB:rdc_pkg::STUP_LSB];
  logic wait_apll;
  logic wait_dpll;
  logic no_wait;
  // The reserved startup code matches none of these and keeps the gate shut.
  assign wait_apll = (stup == rdc_pkg::STUP_APLL) && apll_s;
  assign wait_dpll = (stup == rdc_pkg::STUP_DPLL) && dpll_s;
  assign no_wait = (stup == rdc_pkg::STUP_NONE);
  assign lock_seen = wait_apll || wait_dpll || no_wait;

  always_comb
  begin
    case (gate_ff)
      rdc_pkg::ST_HOLD: nxt_gate = lock_seen ? rdc_pkg::ST_LOCKED
                                             : rdc_pkg::ST_HOLD;
      rdc_pkg::ST_LOCKED: nxt_gate = rdc_pkg::ST_LOCKED;
      default: nxt_gate = rdc_pkg::ST_HOLD;
    endcase
  end
  logic oe_active;
  logic oe_allows;
  logic out_en_ff;
  assign oe_active = oe_s ^ oe_ff[rdc_pkg::OE_POL_BIT];
  assign oe_allows = oe_ff[rdc_pkg::OE_SEL_BIT] || oe_active;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      gate_ff <= rdc_pkg::ST_HOLD;
    else
      gate_ff <= nxt_gate;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      out_en_ff <= 1'b0;
    else
      out_en_ff <= (gate_ff == rdc_pkg::ST_LOCKED) && oe_allows;
  end

  assign out_enable_o = out_en_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Pad controls come straight from the register flip-flops.
  assign oe_pin_pulldown_o = oe_ff[rdc_pkg::OE_PIN_PULLDOWN_BIT];
  assign oe_pin_pullup_o = oe_ff[rdc_pkg::OE_PIN_PULLUP_BIT];
  assign push_pull_strength_o = io_ff[rdc_pkg::PP_MSB:rdc_pkg::PP_LSB];
  assign open_drain_strength_o = io_ff[rdc_pkg::OD_MSB:rdc_pkg::OD_LSB];
  assign serial_data_pullup_o = io_ff[rdc_pkg::SDA_BIT];
  assign serial_clock_pullup_o = io_ff[rdc_pkg::SCL_BIT];
endmodule : rdc_regs
`default_nettype wire

// ### rdc_pkg.sv
// Package of register layouts, reset values and encodings for the bank.
`default_nettype none
package rdc_pkg;
  localparam logic [1:0] REG_PREDIV = 2'h0;
  localparam logic [1:0] REG_OE = 2'h1;
  localparam logic [1:0] REG_IO = 2'h2;
  localparam int PRI_BIT = 24;
  localparam int SETB_BIT = 22;
  localparam int ENB_BIT = 21;
  localparam int BYP_BIT = 20;
  localparam int RATIO_MSB = 19;
  localparam int RATIO_W = 20;
  localparam int OE_PIN_PULLDOWN_BIT = 5;
  localparam int OE_PIN_PULLUP_BIT = 4;
  localparam int OE_POL_BIT = 3;
  localparam int OE_SEL_BIT = 0;
  localparam int STUP_MSB = 7;
  localparam int STUP_LSB = 6;
  localparam int PP_MSB = 5;
  localparam int PP_LSB = 4;
  localparam int OD_MSB = 3;
  localparam int OD_LSB = 2;
  localparam int SDA_BIT = 1;
  localparam int SCL_BIT = 0;
  localparam logic [31:0] PREDIV_RST = 32'h0050_0000;
  localparam logic [31:0] PREDIV_MASK = 32'h017f_ffff;
  localparam logic [7:0] OE_RST = 8'h10;
  localparam logic [7:0] OE_MASK = 8'h39;
  localparam logic [7:0] IO_RST = 8'h2f;
  localparam logic [RATIO_W-1:0] RATIO_MIN = 20'h0_0002;
  localparam logic [RATIO_W-1:0] RATIO_ONE = 20'h0_0001;
  localparam logic [1:0] STUP_APLL = 2'h0;
  localparam logic [1:0] STUP_DPLL = 2'h1;
  localparam logic [1:0] STUP_NONE = 2'h2;
  typedef enum logic [1:0] {
    ST_HOLD = 2'h0,
    ST_LOCKED = 2'h1
  } rdc_gate_e;
endpackage : rdc_pkg
`default_nettype wire

// ### rdc_sync2.sv
// Two-stage synchroniser for one asynchronous pin level.
`default_nettype none
module rdc_sync2 (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_ff;
  logic q_ff;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end
  assign q_o = q_ff;
endmodule : rdc_sync2
`default_nettype wire

// ### rdc_regs_assertions.sv
// Checker of the register bank effects seen at the block ports.
`default_nettype none
module rdc_regs_chk (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_en_i,
  input wire logic [1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] rdata_o,
  input wire logic out_enable_o,
  input wire logic oe_pin_pulldown_o,
  input wire logic oe_pin_pullup_o,
  input wire logic [1:0] push_pull_strength_o,
  input wire logic [1:0] open_drain_strength_o,
  input wire logic serial_data_pullup_o,
  input wire logic serial_clock_pullup_o,
  input wire logic ratio_err_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  wire logic wr_oe = wr_en_i && addr_i == rdc_pkg::REG_OE;
  wire logic wr_io = wr_en_i && addr_i == rdc_pkg::REG_IO;
  wire logic wr_pd = wr_en_i && addr_i == rdc_pkg::REG_PREDIV;
  ////////////////////////////////////////////////////////////////////////////
  a_oe_pulldown:
    assert property (wr_oe |=> oe_pin_pulldown_o == $past(wdata_i[5]))
    else $error("pull-down bit not applied");
  a_oe_pullup:
    assert property (wr_oe |=> oe_pin_pullup_o == $past(wdata_i[4]))
    else $error("pull-up bit not applied");
  a_pp_strength:
    assert property (wr_io |=> push_pull_strength_o == $past(wdata_i[5:4]))
    else $error("push-pull strength not applied");
  a_od_strength:
    assert property (wr_io |=> open_drain_strength_o == $past(wdata_i[3:2]))
    else $error("open-drain strength not applied");
  a_sda_pullup:
    assert property (wr_io |=> serial_data_pullup_o == $past(wdata_i[1]))
    else $error("data pull-up not applied");
  a_scl_pullup:
    assert property (wr_io |=> serial_clock_pullup_o == $past(wdata_i[0]))
    else $error("clock pull-up not applied");
  a_unmapped_zero:
    assert property (addr_i == 2'h3 |=> rdata_o == 32'h0)
    else $error("unmapped index read nonzero");
  a_prediv_resv:
    assert property (addr_i == rdc_pkg::REG_PREDIV
      |=> (rdata_o & ~rdc_pkg::PREDIV_MASK) == 32'h0)
    else $error("reserved divider bits read nonzero");
  a_ratio_low:
    assert property (wr_pd && !wdata_i[20] && wdata_i[19:0] < 20'h2
      |-> ##[1:3] ratio_err_o)
    else $error("low ratio not flagged");
  a_gate_reset:
    assert property ($fell(srst_i) |-> !out_enable_o)
    else $error("drivers enabled right after reset");
  c_enable: cover property (out_enable_o);
  c_ratio: cover property (ratio_err_o);
  c_pulldown: cover property (oe_pin_pulldown_o);
endmodule : rdc_regs_chk
bind rdc_regs rdc_regs_chk u_rdc_regs_chk (.clk_i(clk_i), .srst_i(srst_i),
  .wr_en_i(wr_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .out_enable_o(out_enable_o), .oe_pin_pulldown_o(oe_pin_pulldown_o),
  .oe_pin_pullup_o(oe_pin_pullup_o),
  .push_pull_strength_o(push_pull_strength_o),
  .open_drain_strength_o(open_drain_strength_o),
  .serial_data_pullup_o(serial_data_pullup_o),
  .serial_clock_pullup_o(serial_clock_pullup_o), .ratio_err_o(ratio_err_o));
`default_nettype wire

// ### rdc_regs_tb.sv
// Self-checking bench for the reference divider and pin configuration bank.
`default_nettype none
module rdc_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0, srst_i = 1'b1, wr_en_i = 1'b0, ref_clk_i = 1'b0;
  logic oe_pin_i = 1'b0, apll_lock_i = 1'b0, dpll_lock_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [31:0] wdata_i = 32'h0;
  logic [3:0] ref_valid_i = 4'h0;
  logic [3:1] peer_priority_i = 3'h0;
  logic [31:0] rdata_o;
  logic [1:0] sel_ref_o, pp, od;
  logic sel_valid_o, div_clk_o, out_en, pd, pu, sda, scl, rerr, div_q;
  int n_mismatch = 0, checked = 0, rises = 0;
  rdc_regs u_rdc_regs (.clk_i(clk_i), .srst_i(srst_i), .wr_en_i(wr_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .ref_clk_i(ref_clk_i), .ref_valid_i(ref_valid_i),
    .peer_priority_i(peer_priority_i), .sel_ref_o(sel_ref_o),
    .sel_valid_o(sel_valid_o), .div_clk_o(div_clk_o), .oe_pin_i(oe_pin_i),
    .apll_lock_i(apll_lock_i), .dpll_lock_i(dpll_lock_i),
    .out_enable_o(out_en), .oe_pin_pulldown_o(pd), .oe_pin_pullup_o(pu),
    .push_pull_strength_o(pp), .open_drain_strength_o(od),
    .serial_data_pullup_o(sda), .serial_clock_pullup_o(scl),
    .ratio_err_o(rerr));
  initial forever #25 clk_i = ~clk_i;
  // Edges are counted at the clock, so the divided output is never missed.
  always @(posedge clk_i)
  begin
    div_q <= div_clk_o;
    if (div_clk_o && !div_q) rises <= rises + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic do_reset;
    srst_i <= 1'b1;
    apll_lock_i <= 1'b0;
    dpll_lock_i <= 1'b0;
    tick(16);
    srst_i <= 1'b0;
  endtask : do_reset
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    tick(2);
    chk(rdata_o, exp);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(2'h0, 32'h0050_0000);
    rd(2'h1, 32'h0000_0010);
    rd(2'h2, 32'h0000_002f);
    chk({26'h0, pp, od, sda, scl}, 32'h2f);
    wr(2'h0, 32'hffff_ffff);
    rd(2'h0, 32'h017f_ffff);
    wr(2'h1, 32'hffff_ffff);
    rd(2'h1, 32'h0000_0039);
    wr(2'h2, 32'h0000_001c);
    tick(1);
    chk({26'h0, pp, od, sda, scl}, 32'h1c);
    wr(2'h3, 32'hffff_ffff);
    rd(2'h3, 32'h0);
    wr(2'h1, 32'h0000_0020);
    tick(1);
    chk({30'h0, pd, pu}, 32'h2);
  endtask : t_regs
  task automatic t_gate;
    for (int m = 0; m < 3; m++)
    begin
      do_reset();
      wr(2'h2, {24'h0, m[1:0], 6'h2f});
      wr(2'h1, 32'h11);
      tick(8);
      chk({31'h0, out_en}, {31'h0, m == 2});
      apll_lock_i <= 1'b1;
      tick(8);
      chk({31'h0, out_en}, {31'h0, m != 1});
      dpll_lock_i <= 1'b1;
      tick(8);
      chk({31'h0, out_en}, 32'h1);
    end
    // Polarity and pin level walked through all four pairings.
    for (int k = 0; k < 4; k++)
    begin
      wr(2'h1, {28'h0, k[1], 3'h0});
      oe_pin_i <= k[0];
      tick(8);
      chk({31'h0, out_en}, {31'h0, k[0] ^ k[1]});
    end
  endtask : t_gate
  task automatic div_case(input logic [31:0] cfg, input int lo, input int hi);
    int r0;
    wr(2'h0, cfg);
    tick(4);
    r0 = rises;
    repeat (64)
    begin
      ref_clk_i <= ~ref_clk_i;
      tick(4);
    end
    chk({31'h0, rises - r0 >= lo && rises - r0 <= hi}, 32'h1);
  endtask : div_case
  task automatic t_div;
    // The reference toggles far below 33 MHz, so bypass is legal.
    // Every ratio used keeps the divided rate under 33 MHz.
    div_case(32'h0050_0000, 31, 33);
    div_case(32'h0040_0004, 7, 9);
    div_case(32'h0040_0002, 15, 17);
    div_case(32'h0000_0004, 0, 0);
    chk({31'h0, div_clk_o}, 32'h1);
    div_case(32'h0060_0004, 0, 0);
    wr(2'h0, 32'h0040_0001);
    tick(3);
    chk({31'h0, rerr}, 32'h1);
  endtask : t_div
  task automatic sel(input logic [31:0] cfg, input logic [3:0] v,
    input logic [3:1] p, input logic [2:0] exp);
    wr(2'h0, cfg);
    ref_valid_i <= v;
    peer_priority_i <= p;
    tick(4);
    chk({29'h0, sel_valid_o, sel_ref_o}, {29'h0, exp});
  endtask : sel
  task automatic t_sel;
    sel(32'h0050_0000, 4'hf, 3'h0, 3'h4);
    sel(32'h0150_0000, 4'hf, 3'h0, 3'h5);
    sel(32'h0050_0000, 4'ha, 3'h4, 3'h5);
    sel(32'h0050_0000, 4'ha, 3'h1, 3'h7);
    sel(32'h0150_0000, 4'h1, 3'h0, 3'h4);
  endtask : t_sel
  initial
  begin
    do_reset();
    t_regs();
    t_gate();
    t_div();
    t_sel();
    final_report();
  end
  initial
  begin
    tick(20000);
    n_mismatch++;
    final_report();
  end
endmodule : rdc_regs_tb
`default_nettype wire
